// File: design/ccthr_pkg.sv
// package: register map, field layout, reset values and decode types for the charge threshold registers
package ccthr_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CCTHR_ADDR_CURRENT = 8'h04;
    localparam logic [7:0] CCTHR_ADDR_VTHRESH = 8'h05;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CCTHR_FAST_LSB  = 2;
    localparam int CCTHR_FAST_MSB  = 6;
    localparam int CCTHR_TRK_LSB   = 0;
    localparam int CCTHR_TRK_MSB   = 1;
    localparam int CCTHR_RDIS_BIT  = 7;
    localparam int CCTHR_RCH_LSB   = 5;
    localparam int CCTHR_RCH_MSB   = 6;
    localparam int CCTHR_DEAD_LSB  = 3;
    localparam int CCTHR_DEAD_MSB  = 4;
    localparam int CCTHR_WEAK_LSB  = 0;
    localparam int CCTHR_WEAK_MSB  = 2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [4:0] CCTHR_FAST_RST = 5'h0e;
    localparam logic [1:0] CCTHR_TRK_RST  = 2'h2;
    localparam logic       CCTHR_RDIS_RST = 1'b0;
    localparam logic [1:0] CCTHR_RCH_RST  = 2'h3;
    localparam logic [1:0] CCTHR_DEAD_RST = 2'h1;
    localparam logic [2:0] CCTHR_WEAK_RST = 3'h3;

    // ****************************************
    // fast current decode
    // ****************************************
    localparam logic [4:0]  CCTHR_FAST_LIN_MAX = 5'h15;
    localparam logic [4:0]  CCTHR_FAST_1200    = 5'h16;
    localparam logic [10:0] CCTHR_MA_STEP      = 11'h032;
    localparam logic [10:0] CCTHR_MA_1200      = 11'h4b0;
    localparam logic [10:0] CCTHR_MA_1300      = 11'h514;

    // decoded settings handed to the charger control loops
    typedef struct packed {
        logic [10:0] fast_ma;
        logic [6:0]  trickle_ma;
        logic        recharge_enable;
        logic [8:0]  recharge_mv;
        logic [4:0]  dead_dv;
        logic [5:0]  weak_cv;
    } ccthr_settings_s;

    // register write/read request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccthr_req_s;
endpackage : ccthr_pkg

// File: design/ccthr_decode.sv
// decoder: raw register fields to physical charger settings
`timescale 1ns/1ps
module ccthr_decode (
    input  wire logic [4:0]                fast_charge_current_code,
    input  wire logic [1:0]                trickle_weak_current_code,
    input  wire logic                      recharge_disable,
    input  wire logic [1:0]                recharge_threshold_code,
    input  wire logic [1:0]                dead_battery_threshold_code,
    input  wire logic [2:0]                weak_battery_threshold_code,
    output ccthr_pkg::ccthr_settings_s     settings
);
    always_comb begin
        if (fast_charge_current_code <= ccthr_pkg::CCTHR_FAST_LIN_MAX) begin
            settings.fast_ma = 11'((11'(fast_charge_current_code) + 11'h001) * ccthr_pkg::CCTHR_MA_STEP);
        end else if (fast_charge_current_code == ccthr_pkg::CCTHR_FAST_1200) begin
            settings.fast_ma = ccthr_pkg::CCTHR_MA_1200;
        end else begin
            settings.fast_ma = ccthr_pkg::CCTHR_MA_1300;
        end
        unique case (trickle_weak_current_code)
            2'h0: settings.trickle_ma = 7'h05;
            2'h1: settings.trickle_ma = 7'h0a;
            2'h2: settings.trickle_ma = 7'h14;
            2'h3: settings.trickle_ma = 7'h50;
        endcase
        settings.recharge_enable = ~recharge_disable;
        unique case (recharge_threshold_code)
            2'h0: settings.recharge_mv = 9'h050;
            2'h1: settings.recharge_mv = 9'h08c;
            2'h2: settings.recharge_mv = 9'h0c8;
            2'h3: settings.recharge_mv = 9'h104;
        endcase
        // dead battery table, tenths of a volt
        unique case (dead_battery_threshold_code)
            2'h0: settings.dead_dv = 5'h14;
            2'h1: settings.dead_dv = 5'h19;
            2'h2: settings.dead_dv = 5'h1a;
            2'h3: settings.dead_dv = 5'h1d;
        endcase
        // weak threshold, 2.7 v plus 0.1 v steps
        settings.weak_cv = 6'(6'h1b + 6'(weak_battery_threshold_code));
    end
endmodule : ccthr_decode

// File: design/ccthr_regs.sv
// top: charge current and voltage threshold register pair with decoded outputs
`timescale 1ns/1ps
// Overview of operation
// - fast charge current code sits in bits 6:2 of 0x04, codes 0 to 0x15 give 50 to 1100 ma in 50 ma steps.
// - fast code 0x16 decodes to 1200 ma and codes 0x17 to 0x1f decode to 1300 ma.
// - fast charge current code resets to 0x0e, which is 750 ma.
// - trickle/weak current code sits in bits 1:0 of 0x04 as 5/10/20/80 ma and resets to 2.
// - bit 7 of 0x05 disables automatic recharge when set and resets to 0.
// - recharge threshold code sits in bits 6:5 of 0x05 as 80/140/200/260 mv and resets to 3.
// - a set recharge disable suppresses recharge whatever the threshold code.
// - dead battery threshold code sits in bits 4:3 of 0x05 as 2.0/2.5/2.6/2.9 v and resets to 1.
// - weak threshold code sits in bits 2:0 of 0x05 as 2.7 to 3.4 v and resets to 3.
module ccthr_regs (
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  ccthr_pkg::ccthr_req_s      req,
    output logic [7:0]                 rdata,
    output logic                       rvalid,
    output logic [4:0]                 fast_charge_current_code,
    output logic [1:0]                 trickle_weak_current_code,
    output logic                       recharge_disable,
    output logic [1:0]                 recharge_threshold_code,
    output logic [1:0]                 dead_battery_threshold_code,
    output logic [2:0]                 weak_battery_threshold_code,
    output ccthr_pkg::ccthr_settings_s settings
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_r;
    logic rst_n_r;

    // release synchronised so all flops leave reset on one edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] cur_r;
    logic [7:0] cur_nxt;
    logic [7:0] thr_r;
    logic [7:0] thr_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;

    always_comb begin
        cur_nxt    = cur_r;
        thr_nxt    = thr_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = req.rd;
        if (req.wr && req.addr == ccthr_pkg::CCTHR_ADDR_CURRENT) begin
            cur_nxt = req.wdata;
            cur_nxt[7] = 1'b0;
        end
        if (req.wr && req.addr == ccthr_pkg::CCTHR_ADDR_VTHRESH) begin
            thr_nxt = req.wdata;
        end
        // readback of stored fields, unmapped reads zero
        if (req.rd) begin
            unique case (req.addr)
                ccthr_pkg::CCTHR_ADDR_CURRENT: rdata_nxt = cur_r;
                ccthr_pkg::CCTHR_ADDR_VTHRESH: rdata_nxt = thr_r;
                default:                       rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cur_r    <= {1'b0, ccthr_pkg::CCTHR_FAST_RST, ccthr_pkg::CCTHR_TRK_RST};
            thr_r    <= {ccthr_pkg::CCTHR_RDIS_RST, ccthr_pkg::CCTHR_RCH_RST,
                         ccthr_pkg::CCTHR_DEAD_RST, ccthr_pkg::CCTHR_WEAK_RST};
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            cur_r    <= cur_nxt;
            thr_r    <= thr_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // ****************************************
    // field outputs
    // ****************************************
    assign rdata                       = rdata_r;
    assign rvalid                      = rvalid_r;
    assign fast_charge_current_code    = cur_r[ccthr_pkg::CCTHR_FAST_MSB:ccthr_pkg::CCTHR_FAST_LSB];
    assign trickle_weak_current_code   = cur_r[ccthr_pkg::CCTHR_TRK_MSB:ccthr_pkg::CCTHR_TRK_LSB];
    assign recharge_disable            = thr_r[ccthr_pkg::CCTHR_RDIS_BIT];
    assign recharge_threshold_code     = thr_r[ccthr_pkg::CCTHR_RCH_MSB:ccthr_pkg::CCTHR_RCH_LSB];
    assign dead_battery_threshold_code = thr_r[ccthr_pkg::CCTHR_DEAD_MSB:ccthr_pkg::CCTHR_DEAD_LSB];
    assign weak_battery_threshold_code = thr_r[ccthr_pkg::CCTHR_WEAK_MSB:ccthr_pkg::CCTHR_WEAK_LSB];

    // decode is combinational off the registers, so no extra latency
    ccthr_decode u_decode (
        .fast_charge_current_code    (fast_charge_current_code),
        .trickle_weak_current_code   (trickle_weak_current_code),
        .recharge_disable            (recharge_disable),
        .recharge_threshold_code     (recharge_threshold_code),
        .dead_battery_threshold_code (dead_battery_threshold_code),
        .weak_battery_threshold_code (weak_battery_threshold_code),
        .settings                    (settings)
    );
endmodule : ccthr_regs

// File: test/ccthr_regs_properties.sv
// checker: decode and bus timing properties
`timescale 1ns/1ps
module ccthr_props (
    input wire logic                  ref_clk,
    input wire logic                  arst_n,
    input ccthr_pkg::ccthr_req_s      req,
    input wire logic [7:0]            rdata,
    input wire logic                  rvalid,
    input wire logic [4:0]            fast_charge_current_code,
    input wire logic [1:0]            trickle_weak_current_code,
    input wire logic                  recharge_disable,
    input wire logic [1:0]            recharge_threshold_code,
    input wire logic [1:0]            dead_battery_threshold_code,
    input wire logic [2:0]            weak_battery_threshold_code,
    input ccthr_pkg::ccthr_settings_s settings
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire logic [4:0] fc  = fast_charge_current_code;
    wire logic [1:0] trk = trickle_weak_current_code;
    wire logic [1:0] rch = recharge_threshold_code;
    wire logic [1:0] dbt = dead_battery_threshold_code;
    chk_fast_decode: assert property (settings.fast_ma == (fc <= 5'h15 ? 11'(fc) * 11'h032 + 11'h032 :
        fc == 5'h16 ? 11'h4b0 : 11'h514)) else $error("bad fast current");
    chk_trickle_decode: assert property (settings.trickle_ma == (trk == 2'h3 ? 7'h50 : 7'h05 << trk))
        else $error("bad trickle current");
    chk_recharge_off: assert property (settings.recharge_enable == !recharge_disable)
        else $error("bad enable");
    chk_hyst_decode: assert property (settings.recharge_mv == 9'h050 + 9'(rch) * 9'h03c)
        else $error("bad recharge level");
    chk_dead_decode: assert property (settings.dead_dv == (dbt == 2'h0 ? 5'h14 : dbt == 2'h1 ? 5'h19 :
        dbt == 2'h2 ? 5'h1a : 5'h1d)) else $error("bad dead level");
    chk_weak_decode: assert property (settings.weak_cv == 6'h1b + 6'(weak_battery_threshold_code))
        else $error("bad weak level");
    chk_read_pulse: assert property (rvalid == $past(req.rd)) else $error("bad read pulse");
    chk_bit7_zero: assert property (req.rd && req.addr == 8'h04 |=> !rdata[7])
        else $error("unused bit set");
    chk_unmapped_read: assert property (req.rd && req.addr != 8'h04 && req.addr != 8'h05 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_fast_write: assert property (req.wr && req.addr == 8'h04 |=> fc == $past(req.wdata[6:2]))
        else $error("fast code not taken");
    chk_trk_write: assert property (req.wr && req.addr == 8'h04 |=> trk == $past(req.wdata[1:0]))
        else $error("trickle code not taken");
    chk_rdis_write: assert property (req.wr && req.addr == 8'h05 |=>
        recharge_disable == $past(req.wdata[7])) else $error("disable not taken");
    chk_rch_write: assert property (req.wr && req.addr == 8'h05 |=> rch == $past(req.wdata[6:5]))
        else $error("recharge code not taken");
    chk_dead_write: assert property (req.wr && req.addr == 8'h05 |=> dbt == $past(req.wdata[4:3]))
        else $error("dead code not taken");
    chk_weak_write: assert property (req.wr && req.addr == 8'h05 |=>
        weak_battery_threshold_code == $past(req.wdata[2:0])) else $error("weak code not taken");
    chk_fields_hold: assert property (!req.wr |=> $stable({fc, trk, recharge_disable, rch, dbt,
        weak_battery_threshold_code})) else $error("field moved without write");
    cover property (req.wr && req.addr == 8'h04 && req.wdata[7]);
    cover property (req.wr && req.addr == 8'h05 && req.wdata[7]);
    cover property (rvalid && !req.rd);
    cover property (req.wr && req.rd && req.addr == 8'h04);
endmodule : ccthr_props
bind ccthr_regs ccthr_props u_props (.ref_clk, .arst_n, .req, .rdata, .rvalid, .fast_charge_current_code,
    .trickle_weak_current_code, .recharge_disable, .recharge_threshold_code, .dead_battery_threshold_code,
    .weak_battery_threshold_code, .settings);

// File: test/tb.sv
// testbench: directed register and decode scenarios
`timescale 1ns/1ps
module tb;
    logic                       ref_clk = 1'b0;
    logic                       arst_n;
    ccthr_pkg::ccthr_req_s      req;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic [4:0]                 fast_charge_current_code;
    logic [1:0]                 trickle_weak_current_code;
    logic                       recharge_disable;
    logic [1:0]                 recharge_threshold_code;
    logic [1:0]                 dead_battery_threshold_code;
    logic [2:0]                 weak_battery_threshold_code;
    ccthr_pkg::ccthr_settings_s settings;
    int                         mismatches = 0;
    int                         n_checks = 0;
    // raw field codes and decoded settings in one word
    wire logic [63:0]           observed = {10'h000, fast_charge_current_code, trickle_weak_current_code,
        recharge_disable, recharge_threshold_code, dead_battery_threshold_code, weak_battery_threshold_code,
        settings};
    ccthr_regs uut (.ref_clk, .arst_n, .req, .rdata, .rvalid, .fast_charge_current_code, .trickle_weak_current_code,
        .recharge_disable, .recharge_threshold_code, .dead_battery_threshold_code, .weak_battery_threshold_code,
        .settings);
    initial forever #20 ref_clk = ~ref_clk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        mismatches += int'(got !== exp);
        if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    endtask : chk
    // own model of the field tables, kept apart from the design's decoder
    function automatic logic [63:0] dec(input logic [7:0] c, input logic [7:0] t);
        return {10'h000, c[6:0], t,
            c[6:2] <= 5'h15 ? 11'(c[6:2]) * 11'h032 + 11'h032 : c[6:2] == 5'h16 ? 11'h4b0 : 11'h514,
            c[1:0] == 2'h3 ? 7'h50 : 7'h05 << c[1:0], ~t[7], 9'h050 + 9'(t[6:5]) * 9'h03c,
            t[4:3] == 2'h3 ? 5'h1d : t[4:3] == 2'h0 ? 5'h14 : 5'h18 + 5'(t[4:3]), 6'h1b + 6'(t[2:0])};
    endfunction : dec
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = {1'b1, 1'b0, a, d};
        @(negedge ref_clk);
    endtask : wr
    // strobe stays up into the next call, so back-to-back requests need no gap
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        req = {1'b0, 1'b1, a, 8'h00};
        @(negedge ref_clk);
        chk({55'h0, rvalid, rdata}, {55'h0, 1'b1, e});
    endtask : rd
    task automatic t_reset(input int n);
        req = '0;
        arst_n = 1'b0;
        repeat (n) @(negedge ref_clk);
        chk(observed, dec(8'h3a, 8'h6b));
        chk({55'h0, rvalid, rdata}, 64'h0);
        arst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd(8'h04, 8'h3a);
        rd(8'h05, 8'h6b);
    endtask : t_reset
    task automatic t_current();
        for (int i = 0; i < 32; i++) begin
            wr(8'h04, {1'b1, 5'(i), 2'(i)});
            chk(observed, dec({1'b0, 5'(i), 2'(i)}, 8'h6b));
            rd(8'h04, {1'b0, 5'(i), 2'(i)});
        end
    endtask : t_current
    task automatic t_thresh();
        for (int i = 0; i < 9; i++) begin
            wr(8'h05, 8'(i * 8'h25));
            chk(observed, dec(8'h7f, 8'(i * 8'h25)));
            rd(8'h05, 8'(i * 8'h25));
        end
        wr(8'h06, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h05, 8'h28);
    endtask : t_thresh
    // read and write together return the byte held before the write
    task automatic t_rw_same();
        req = {1'b1, 1'b1, 8'h04, 8'h55};
        @(negedge ref_clk);
        chk({55'h0, rvalid, rdata}, {55'h0, 1'b1, 8'h7f});
        chk(observed, dec(8'h55, 8'h28));
        rd(8'h04, 8'h55);
    endtask : t_rw_same
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        t_reset(16);
        t_current();
        t_thresh();
        t_rw_same();
        t_reset(1);
        close_out();
    end
endmodule : tb
